/* File: hdl/csc_charge_seq.sv */
// Purpose: start-up, timer, termination and status sequencing of a charger
// Assumes: comparator results arrive asynchronously and are synchronised here
// Notes: open-drain pins are split into output value and enable

`timescale 1ns/1ps

// Operation
// RULE_01: strong pull-down on charge status while actively charging.
// RULE_02: below tenth current, release strong pull-down, enable weak sink.
// RULE_03: timer expiry or supply loss leaves charge status high impedance.
// RULE_04: charge status held below 1V disables timer, conditioning continues. Code senses it only with strong pull-down off, so not in conditioning.
// RULE_05: adapter pin floats high when supply fine; held low inhibits charging.
// RULE_06: short low pulse on adapter pin resets and restarts the charger.
// RULE_07: total charge time set by timer resistor, one hour per 154k.
// RULE_08: no timer resistor, no charge cycle starts.
// RULE_09: unsafe thermistor suspends charging and timer; both resume later.
// RULE_10: thermistor network is sampled at regular intervals only.
// RULE_11: start only with supply above reference, above lockout, pin high.
// RULE_12: cell below 2.5V at start enters conditioning at tenth current.
// RULE_13: cell below 2.5V for quarter time terminates with fault.
// RULE_14: tenth-current detection latches and reloads timer to quarter left.
// RULE_15: tenth-current detection inhibited while input current limited.
// RULE_16: timer expiry stops charging at once, status high impedance.
// RULE_17: after termination, cell below 3.9V restarts a cycle.
// RULE_18: supply removal and return, or adapter pin low, restarts.
// RULE_19: without input voltage the block enters sleep mode.
// RULE_20: float divider disconnected during shutdown.
// RULE_21: supply 25mV below reference drives adapter pin low, disables charger.
// RULE_22: charge timer counts resistor timebase, compared at quarter and full.
module csc_charge_seq #(
  parameter int unsigned NTC_PERIOD_CYC = csc_pkg::NTC_PERIOD_CYC_DEF
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire csc_pkg::csc_sense_t sense_in,
  output logic charge_status_out,
  output logic charge_status_oe_out,
  output logic charge_status_weak_out,
  output logic adapter_ok_inhibit_pin_out,
  output logic adapter_ok_inhibit_pin_oe_out,
  output csc_pkg::csc_ctrl_t ctrl_out
);
  import csc_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  csc_sense_t s1_q;
  csc_sense_t s_q;
  logic tick_prev_q;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s_q <= '0;
      tick_prev_q <= 1'b0;
    end else begin
      s1_q <= sense_in;
      s_q <= s1_q;
      tick_prev_q <= s_q.tick;
    end
  end

  // ****************************************
  // qualification and decode
  // ****************************************
  csc_state_t st_q;
  csc_state_t st_d;
  logic [TMR_W-1:0] timer_q;
  logic [TMR_W-1:0] timer_d;
  logic c10_q;
  logic cond_q;
  logic ntc_ok_q;
  logic [NTC_CNT_W-1:0] ntc_cnt_q;

  wire qualified = s_q.supply_ok && s_q.undervoltage_lockout_ok && s_q.acp_high
                   && !s_q.supply_rev;  // see RULE_11 see RULE_05 see RULE_21
  wire charging = (st_q == ST_CHARGE);
  wire strong_pd = charging && !c10_q;  // see RULE_01
  wire weak_sink = charging && c10_q;  // see RULE_02
  // sensed level lags our own drive by the synchroniser; a release glitch is tolerated
  wire defeat = s_q.chg_low && !strong_pd;  // see RULE_04
  wire tick_rise = s_q.tick && !tick_prev_q;
  wire tmr_run = charging && ntc_ok_q && !defeat && tick_rise;  // see RULE_09 see RULE_22
  wire c10_take = charging && !c10_q && !cond_q && s_q.c10
                  && !s_q.ilim;  // see RULE_15
  wire lobat_fault = charging && cond_q && !defeat
                     && (timer_q >= TMR_QUARTER);  // see RULE_13
  wire expired = charging && (timer_q >= TMR_FULL);  // see RULE_16 see RULE_07
  wire start = (st_d == ST_CHARGE) && !charging;
  wire ntc_window = (ntc_cnt_q < NTC_SAMPLE_CYC[NTC_CNT_W-1:0]);
  wire ntc_last = (ntc_cnt_q == NTC_SAMPLE_CYC[NTC_CNT_W-1:0] - 16'h0001);
  wire ntc_wrap = (ntc_cnt_q == NTC_PERIOD_CYC[NTC_CNT_W-1:0] - 16'h0001);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF: begin
        if (qualified && s_q.rt_ok) begin  // see RULE_08 see RULE_11
          st_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (!qualified) begin  // see RULE_06 see RULE_18
          st_d = ST_OFF;
        end else if (lobat_fault) begin  // see RULE_13
          st_d = ST_FAULT;
        end else if (expired) begin  // see RULE_16
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!qualified) begin
          st_d = ST_OFF;
        end else if (s_q.cell_restart && s_q.rt_ok) begin  // see RULE_17
          st_d = ST_CHARGE;
        end
      end
      ST_FAULT: begin
        // only a manual restart clears a low-battery fault
        if (!qualified) begin  // see RULE_18
          st_d = ST_OFF;
        end
      end
    endcase
  end

  always_comb begin
    timer_d = timer_q;
    if (start || st_q == ST_OFF) begin
      timer_d = TMR_RESET;
    end else if (c10_take) begin
      timer_d = TMR_RELOAD;  // see RULE_14
    end else if (tmr_run) begin
      timer_d = timer_q + 16'h0001;  // see RULE_22
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_OFF;
      timer_q <= TMR_RESET;
    end else begin
      st_q <= st_d;
      timer_q <= timer_d;
    end
  end

  // tenth-current latch and conditioning flag
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      c10_q <= 1'b0;
      cond_q <= 1'b0;
    end else if (start) begin
      c10_q <= 1'b0;
      cond_q <= s_q.cell_lo;  // see RULE_12
    end else begin
      c10_q <= c10_q || c10_take;  // see RULE_14
      cond_q <= cond_q && s_q.cell_lo;
    end
  end

  // ****************************************
  // thermistor sampler
  // ****************************************
  // sampling keeps the reference off most of the time to save supply current
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ntc_cnt_q <= '0;
      ntc_ok_q <= 1'b0;
    end else begin
      ntc_cnt_q <= ntc_wrap ? '0 : ntc_cnt_q + 16'h0001;  // see RULE_10
      if (ntc_last) begin
        ntc_ok_q <= s_q.ntc_ok;  // see RULE_09
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign charge_status_out = 1'b0;
  assign charge_status_oe_out = strong_pd;  // see RULE_01 see RULE_03
  assign charge_status_weak_out = weak_sink;  // see RULE_02
  assign adapter_ok_inhibit_pin_out = 1'b0;
  assign adapter_ok_inhibit_pin_oe_out = s_q.supply_rev;  // see RULE_21 see RULE_05
  assign ctrl_out.charge_en = charging && ntc_ok_q;  // see RULE_09
  assign ctrl_out.conditioning = charging && cond_q;  // see RULE_12
  assign ctrl_out.divider_en = (st_q != ST_OFF);  // see RULE_20
  assign ctrl_out.sleep = !s_q.supply_ok;  // see RULE_19
  assign ctrl_out.ntc_sample = ntc_window;  // see RULE_10

  // ****************************************
  // assertions
  // ****************************************
  property p_no_resistor;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_OFF && !s_q.rt_ok) |=> (st_q == ST_OFF);
  endproperty
  a_no_resistor: assert property (p_no_resistor) // see RULE_08
    else $error("charge started without timer resistor");

  property p_start;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_OFF && qualified && s_q.rt_ok)
      |=> charging && charge_status_oe_out && timer_q == TMR_RESET;
  endproperty
  a_start: assert property (p_start) // see RULE_11
    else $error("qualified start did not begin charging");

  property p_inhibit;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !s_q.acp_high |=> (st_q == ST_OFF) && !ctrl_out.charge_en;
  endproperty
  a_inhibit: assert property (p_inhibit) // see RULE_05
    else $error("adapter pin low did not inhibit charging");

  property p_reverse;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    s_q.supply_rev |-> adapter_ok_inhibit_pin_oe_out ##1 !charging;
  endproperty
  a_reverse: assert property (p_reverse) // see RULE_21
    else $error("reverse supply not handled");

  property p_tenth;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (c10_take && st_d == ST_CHARGE)
      |=> c10_q && timer_q == TMR_RELOAD && charge_status_weak_out
          && !charge_status_oe_out;
  endproperty
  a_tenth: assert property (p_tenth) // see RULE_14
    else $error("tenth-current detection not latched with reload");

  property p_limit;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (charging && !c10_q && s_q.ilim) |=> !c10_q;
  endproperty
  a_limit: assert property (p_limit) // see RULE_15
    else $error("tenth-current detected during current limit");

  property p_expire;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (expired && qualified && !lobat_fault)
      |=> st_q == ST_DONE && !charge_status_oe_out && !charge_status_weak_out
          && !ctrl_out.charge_en;
  endproperty
  a_expire: assert property (p_expire) // see RULE_16
    else $error("timer expiry did not terminate");

  property p_lobat;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (lobat_fault && qualified) |=> st_q == ST_FAULT ##1 !charge_status_oe_out;
  endproperty
  a_lobat: assert property (p_lobat) // see RULE_13
    else $error("low-battery timeout did not fault");

  property p_restart;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_DONE && qualified && s_q.cell_restart && s_q.rt_ok)
      |=> charging && timer_q == TMR_RESET;
  endproperty
  a_restart: assert property (p_restart) // see RULE_17
    else $error("automatic restart missed");

  property p_pause;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (charging && !ntc_ok_q && !c10_take && st_d == ST_CHARGE)
      |-> !ctrl_out.charge_en ##1 timer_q == $past(timer_q);
  endproperty
  a_pause: assert property (p_pause) // see RULE_09
    else $error("thermistor pause did not hold timer");

  property p_defeat;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (charging && defeat && !c10_take && st_d == ST_CHARGE)
      |=> timer_q == $past(timer_q);
  endproperty
  a_defeat: assert property (p_defeat) // see RULE_04
    else $error("timer ran while defeated");

  property p_shutdown;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (!s_q.supply_ok) |-> ctrl_out.sleep ##1 !ctrl_out.divider_en;
  endproperty
  a_shutdown: assert property (p_shutdown) // see RULE_19 see RULE_20
    else $error("supply loss did not sleep and disconnect divider");

  property p_supply_loss;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !s_q.supply_ok |=> !charge_status_oe_out && !charge_status_weak_out;
  endproperty
  a_supply_loss: assert property (p_supply_loss) // see RULE_03
    else $error("supply loss left charge status driven");

  property p_cond_start;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_OFF && qualified && s_q.rt_ok && s_q.cell_lo) |=> ctrl_out.conditioning;
  endproperty
  a_cond_start: assert property (p_cond_start) // see RULE_12
    else $error("depleted cell did not start in conditioning");

  property p_sample_only;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !$stable(ntc_ok_q) |-> $past(ctrl_out.ntc_sample);
  endproperty
  a_sample_only: assert property (p_sample_only) // see RULE_10
    else $error("thermistor verdict changed outside a sample window");

  property p_tick_only;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (charging && !tick_rise && !c10_take && st_d == ST_CHARGE)
      |=> timer_q == $past(timer_q);
  endproperty
  a_tick_only: assert property (p_tick_only) // see RULE_22
    else $error("timer advanced without a timebase edge");

  property p_fault_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_FAULT && qualified) |=> st_q == ST_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold) // see RULE_13
    else $error("low-battery fault left without manual restart");

  property p_done_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q == ST_DONE && qualified && !s_q.cell_restart) |=> st_q == ST_DONE;
  endproperty
  a_done_hold: assert property (p_done_hold) // see RULE_17
    else $error("restart without low cell voltage");

  property p_unqualify;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (st_q != ST_OFF && !qualified) |=> st_q == ST_OFF ##1 timer_q == TMR_RESET;
  endproperty
  a_unqualify: assert property (p_unqualify) // see RULE_06
    else $error("loss of qualification did not reset the charger");

  property p_c10_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (charging && c10_q && st_d == ST_CHARGE) |=> c10_q && charge_status_weak_out;
  endproperty
  a_c10_hold: assert property (p_c10_hold) // see RULE_14
    else $error("tenth-current latch dropped while charging");

endmodule : csc_charge_seq

/* File: hdl/csc_pkg.sv */
// Purpose: shared types and constants of the charge sequencer
// Assumes: 20 MHz system clock
// Notes: timer counts are in timebase ticks, not system cycles

package csc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CLK_MHZ = 1000 / CLK_PERIOD_NS;
  // thermistor sampling interval and sample window
  localparam int unsigned NTC_PERIOD_US = 1000;
  localparam int unsigned NTC_PERIOD_CYC_DEF = NTC_PERIOD_US * CLK_MHZ;
  localparam int unsigned NTC_SAMPLE_US = 10;
  localparam int unsigned NTC_SAMPLE_CYC = NTC_SAMPLE_US * CLK_MHZ;
  localparam int unsigned NTC_CNT_W = 16;

  // ****************************************
  // charge timer
  // ****************************************
  localparam int unsigned TMR_W = 16;
  // full count of resistor timebase ticks for one total charge time
  localparam logic [TMR_W-1:0] TMR_FULL = 16'h4000;
  localparam logic [TMR_W-1:0] TMR_QUARTER = TMR_FULL >> 2;
  localparam logic [TMR_W-1:0] TMR_RELOAD = TMR_FULL - TMR_QUARTER;
  localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_OFF,
    ST_CHARGE,
    ST_DONE,
    ST_FAULT
  } csc_state_t;

  // comparator results from the analog side, all active high
  typedef struct packed {
    logic supply_ok;     // supply_input above supply_reference
    logic supply_rev;    // supply_input 25 mV below supply_reference
    logic undervoltage_lockout_ok;       // above undervoltage_lockout
    logic acp_high;      // adapter_ok_inhibit_pin level above 1 V
    logic chg_low;       // charge_status_out level below 1 V
    logic rt_ok;         // timer resistor present
    logic cell_lo;       // cell below 2.5 V
    logic cell_restart;  // cell below 3.9 V
    logic c10;           // charge current below tenth of programmed
    logic ilim;          // input current limit active
    logic ntc_ok;        // thermistor within limits
    logic tick;          // resistor-derived timebase
  } csc_sense_t;

  // controls towards the analog power stage
  typedef struct packed {
    logic charge_en;
    logic conditioning;  // tenth of programmed current
    logic divider_en;    // float divider on battery sense
    logic sleep;
    logic ntc_sample;    // thermistor reference enabled
  } csc_ctrl_t;

endpackage : csc_pkg

/* File: verif/csc_partner_model.sv */
// Purpose: far-side model of resistor timebase, thermistor and pin wiring
// Assumes: timebase oscillator runs free, pull-ups on both open-drain pins
// Notes: levels of the open-drain pins are resolved here

`timescale 1ns/1ps

module csc_partner_model #(
  parameter int unsigned TICK_HALF = 2
) (
  input wire logic sys_clk_in,
  input wire csc_pkg::csc_ctrl_t ctrl_in,
  input wire logic temp_safe_in,
  input wire logic status_oe_in,
  input wire logic status_force_low_in,
  input wire logic pin_oe_in,
  input wire logic pin_hold_low_in,
  output logic tick_out,
  output logic ntc_ok_out,
  output logic chg_low_out,
  output logic acp_high_out
);
  import csc_pkg::*;

  // ****************************************
  // timebase and wire levels
  // ****************************************
  int unsigned half_q = 0;
  logic tick_q = 1'b0;

  always_ff @(posedge sys_clk_in) begin
    if (half_q == TICK_HALF - 1) begin
      half_q <= 0;
      tick_q <= ~tick_q;
    end else begin
      half_q <= half_q + 1;
    end
  end

  assign tick_out = tick_q;
  // reference off: comparator level is garbage, so show the wrong one
  assign ntc_ok_out = ctrl_in.ntc_sample ? temp_safe_in : ~temp_safe_in;
  // weak sink against the pull-up stays above 1 V
  assign chg_low_out = status_oe_in | status_force_low_in;
  assign acp_high_out = ~(pin_oe_in | pin_hold_low_in);
endmodule : csc_partner_model

/* File: verif/charge_sequence_control_tb_top.sv */
// Purpose: self-checking bench of the charge sequencer
// Assumes: tick every 4 cycles, thermistor period shortened to 400 cycles
// Notes: outputs packed as oe, weak, charge_en, conditioning, divider, sleep, pin_oe

`timescale 1ns/1ps

module charge_sequence_control_tb_top;
  import csc_pkg::*;

  // ****************************************
  // signals and instances
  // ****************************************
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  csc_sense_t drv = '0;
  csc_sense_t sense_w;
  csc_ctrl_t ctrl_w;
  logic temp_safe = 1'b1;
  logic force_low = 1'b0;
  logic hold_low = 1'b0;
  logic st_oe, st_weak, st_val, pin_val, pin_oe;
  logic tick_w, ntc_w, chg_w, acp_w;
  logic [6:0] exp_q[$];
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int window_cnt = 0;
  int win_base = 0;
  int seed = 32'h729E;
  event sample_ev;
  wire logic [6:0] obs = {st_oe, st_weak, ctrl_w.charge_en, ctrl_w.conditioning,
                          ctrl_w.divider_en, ctrl_w.sleep, pin_oe};

  assign sense_w = {drv.supply_ok, drv.supply_rev, drv.undervoltage_lockout_ok, acp_w, chg_w, drv.rt_ok,
                    drv.cell_lo, drv.cell_restart, drv.c10, drv.ilim, ntc_w, tick_w};

  always #25 sys_clk_in = ~sys_clk_in;

  csc_charge_seq #(.NTC_PERIOD_CYC(400)) dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .sense_in(sense_w), .charge_status_out(st_val), .charge_status_oe_out(st_oe),
    .charge_status_weak_out(st_weak), .adapter_ok_inhibit_pin_out(pin_val),
    .adapter_ok_inhibit_pin_oe_out(pin_oe), .ctrl_out(ctrl_w));

  csc_partner_model #(.TICK_HALF(2)) partner_u (.sys_clk_in(sys_clk_in), .ctrl_in(ctrl_w),
    .temp_safe_in(temp_safe), .status_oe_in(st_oe), .status_force_low_in(force_low),
    .pin_oe_in(pin_oe), .pin_hold_low_in(hold_low), .tick_out(tick_w), .ntc_ok_out(ntc_w),
    .chg_low_out(chg_w), .acp_high_out(acp_w));

  // ****************************************
  // tasks
  // ****************************************
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(int n);
    repeat (n) @(posedge sys_clk_in);
    #5;
  endtask : step

  task automatic expect_out(logic [6:0] e);
    exp_q.push_back(e);
    ->sample_ev;
  endtask : expect_out

  always @(sample_ev) begin
    check("outputs", {9'h000, obs}, {9'h000, exp_q.pop_front()});
    check("pin_levels", {14'h0000, st_val, pin_val}, 16'h0000);
  end

  // ntc_sample settles after the rising edge, so count it on the falling one
  always @(negedge sys_clk_in) begin
    window_cnt += int'(ctrl_w.ntc_sample);
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    step(12);
    rst_n_in = 1'b1;
    step(2);
    expect_out(7'h02);
    drv.supply_ok = 1'b1;
    drv.undervoltage_lockout_ok = 1'b1;
    step(8);
    expect_out(7'h00);
    drv.rt_ok = 1'b1;
    step(5);
    expect_out(7'h44);
    win_base = window_cnt;
    step(400);
    check("sample_window", 16'(window_cnt - win_base), 16'(NTC_SAMPLE_CYC));
    step(50);
    expect_out(7'h54);
    temp_safe = 1'b0;
    step(450);
    expect_out(7'h44);
    temp_safe = 1'b1;
    step(450);
    expect_out(7'h54);
    drv.c10 = 1'b1;
    repeat (40) begin
      drv.ilim = 1'b1;
      drv.cell_restart = 1'($random(seed));
      step(1);
    end
    expect_out(7'h54);
    drv.cell_restart = 1'b0;
    drv.ilim = 1'b0;
    step(5);
    expect_out(7'h34);
    force_low = 1'b1;
    step(8000);
    force_low = 1'b0;
    step(8384);
    expect_out(7'h34);
    step(8100);
    expect_out(7'h04);
    drv.c10 = 1'b0;
    drv.cell_restart = 1'b1;
    step(5);
    expect_out(7'h54);
    drv.cell_restart = 1'b0;
    drv.supply_ok = 1'b0;
    step(5);
    expect_out(7'h02);
    drv.cell_lo = 1'b1;
    drv.supply_ok = 1'b1;
    step(5);
    expect_out(7'h5C);
    step(16284);
    expect_out(7'h5C);
    step(200);
    expect_out(7'h04);
    drv.cell_lo = 1'b0;
    hold_low = 1'b1;
    step(2);
    hold_low = 1'b0;
    step(8);
    expect_out(7'h54);
    drv.supply_rev = 1'b1;
    step(5);
    expect_out(7'h01);
    step(2);
    finish_test();
  end
endmodule : charge_sequence_control_tb_top
